// ===== adcss_conv_model.sv
// Behavioural converter core: channel-coded result while converting, noise otherwise.
`timescale 1ns/100ps
`default_nettype none
module adcss_conv_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] adc_chan_sel,
  input wire logic adc_convert,
  output logic [9:0] adc_code
);
  logic [9:0] junk_q;
  logic [9:0] junk_d;
  // Toggling pattern so a late capture never sees a stale code
  always_comb begin
    junk_d = ~junk_q;
  end
  always_ff @(posedge clk) begin
    junk_q <= sys_rst ? 10'h155 : junk_d;
  end
  // Code carries the channel so the bench can tell results apart
  assign adc_code = adc_convert ? {adc_chan_sel, 5'h0B} : junk_q;
endmodule : adcss_conv_model
`default_nettype wire

// ===== adcss_down_cnt.sv
// Loadable down counter used for the enable, sample and conversion periods.
`timescale 1ns/100ps
`default_nettype none
module adcss_down_cnt #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic zero
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Load wins; otherwise count down and stop at zero
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  // Counter register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign zero = (cnt_q == '0);
endmodule : adcss_down_cnt
`default_nettype wire

// ===== adcss_pkg.sv
// Package for the converter sense sequencer: offsets, fields, timing constants.
package adcss_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned CONV_CYCLES = 12;
  localparam int unsigned INT_HOLD_CYCLES = 2;
  localparam int unsigned AUTO_FIRST = 0;
  localparam int unsigned AUTO_LAST = 10;
  localparam int unsigned ROBIN_LAST = 11;
  localparam int unsigned SWEEP_TIME_US = 696;
  localparam int unsigned CHAN_TIME_NS = 63330;
  localparam int unsigned CHAN_CYCLES = (CHAN_TIME_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned SLOT_FIXED = CONV_CYCLES + INT_HOLD_CYCLES + 2;
  localparam logic [31:0] AUTO_MAP_RST = 32'h000007FF;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_EN_DLY = 8'h04;
  localparam logic [7:0] REG_SMP = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_ST = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [7:0] REG_LAST = 8'h18;
  localparam logic [7:0] REG_AUTO_MAP = 8'h1C;
  localparam logic [7:0] REG_RESULT0 = 8'h40;
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_CONT = 1;
  localparam int unsigned CTRL_MODE_LO = 2;
  localparam int unsigned CTRL_CHAN_LO = 8;
  localparam int unsigned CTRL_AVG_LO = 16;
  localparam logic [15:0] EN_DLY_RST = 16'h0010;
  localparam logic [15:0] SMP_RST = 16'h0008;
  localparam logic [31:0] CTRL_RST = 32'h00010000;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_SWEEP = 1;
  localparam int unsigned IRQ_AVG = 2;
  typedef enum logic [1:0] {
    ADCSS_MODE_SINGLE = 2'h0,
    ADCSS_MODE_ROBIN = 2'h1,
    ADCSS_MODE_ONCE = 2'h2
  } adcss_mode_t;
  typedef enum logic [5:0] {
    ADCSS_IDLE = 6'h01,
    ADCSS_ENWAIT = 6'h02,
    ADCSS_SAMPLE = 6'h04,
    ADCSS_CONVERT = 6'h08,
    ADCSS_INTHOLD = 6'h10,
    ADCSS_HALT = 6'h20
  } adcss_state_t;
endpackage : adcss_pkg

// ===== adcss_seq.sv
// Sense sequencer top: register port, mode state machine, converter handshake, results.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module adcss_seq
  import adcss_pkg::*;
#(
  parameter int NCHAN = 32,
  parameter int DW = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic adc_done_int,
  output logic [4:0] adc_chan_sel,
  output logic adc_sample,
  output logic adc_convert,
  input wire logic [DW-1:0] adc_code
);
  // Control registers
  logic [31:0] ctrl_q, ctrl_d;
  logic [15:0] en_dly_q, en_dly_d;
  logic [15:0] smp_q, smp_d;
  logic [2:0] irq_st_q, irq_st_d;
  logic [2:0] irq_mask_q, irq_mask_d;
  logic [31:0] auto_map_q, auto_map_d;
  logic [DW-1:0] last_q, last_d;
  logic [DW-1:0] result_q [NCHAN];
  logic [31:0] rdata_d;
  logic [7:0] res_off;
  logic irq_d;

  // Sequencer state
  adcss_state_t state_q, state_d;
  logic [4:0] chan_q, chan_d;
  logic [4:0] cur_q, cur_d;
  logic [1:0] hold_q, hold_d;
  logic [15:0] pace_gap;
  logic [2:0] ev;
  logic cnt_load;
  logic [15:0] cnt_val;
  logic cnt_zero;
  logic res_we;

  wire logic en = ctrl_q[CTRL_EN];
  wire logic cont = ctrl_q[CTRL_CONT];
  wire adcss_mode_t mode = adcss_mode_t'(ctrl_q[CTRL_MODE_LO +: 2]);
  wire logic [4:0] sel_chan = ctrl_q[CTRL_CHAN_LO +: 5];
  wire logic avg_bad = (ctrl_q[CTRL_AVG_LO +: 4] != 4'h1);

  // Next round-robin channel: 0..11 in order, wrapping back to the first
  function automatic logic [4:0] next_auto(input logic [4:0] c);
    next_auto = (c >= 5'(ROBIN_LAST)) ? 5'(AUTO_FIRST) : c + 5'h01;
  endfunction : next_auto

  // Slot pacing for the automatic modes: each channel slot is stretched to the
  // channel period by idling in the wait state. A long sample window eats the gap,
  // so slots then run longer than the period rather than cutting a phase short.
  always_comb begin
    pace_gap = 16'h0000;
    if (32'(smp_q) + SLOT_FIXED < CHAN_CYCLES) begin
      pace_gap = 16'(CHAN_CYCLES - SLOT_FIXED - 32'(smp_q));
    end
  end

  // One shared timer serves the programmable periods and the conversion period; the done hold counts on hold_q
  adcss_down_cnt #(.W(16)) u_cnt (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(cnt_load),
    .load_val(cnt_val),
    .zero(cnt_zero)
  );

  // Mode state machine; a running conversion always completes before a change takes effect
  always_comb begin
    state_d = state_q;
    chan_d = chan_q;
    cur_d = cur_q;
    hold_d = hold_q;
    cnt_load = 1'b0;
    cnt_val = 16'h0000;
    res_we = 1'b0;
    ev = 3'h0;
    case (state_q)
      ADCSS_IDLE: begin
        if (en) begin
          state_d = ADCSS_ENWAIT;
          cnt_load = 1'b1;
          cnt_val = en_dly_q;
          chan_d = (mode == ADCSS_MODE_SINGLE) ? sel_chan : 5'(AUTO_FIRST);
        end
      end
      ADCSS_ENWAIT: begin
        if (!en) begin
          state_d = ADCSS_IDLE;
        end else if (cnt_zero) begin
          state_d = ADCSS_SAMPLE;
          cnt_load = 1'b1;
          cnt_val = smp_q;
          cur_d = chan_q; // Channel frozen for this conversion
        end
      end
      ADCSS_SAMPLE: begin
        if (cnt_zero) begin
          state_d = ADCSS_CONVERT;
          cnt_load = 1'b1;
          cnt_val = 16'(CONV_CYCLES - 1);
        end
      end
      ADCSS_CONVERT: begin
        if (cnt_zero) begin
          state_d = ADCSS_INTHOLD;
          res_we = 1'b1; // Whole code written in one edge
          hold_d = 2'(INT_HOLD_CYCLES - 1);
          ev[IRQ_DONE] = 1'b1;
        end
      end
      ADCSS_INTHOLD: begin
        hold_d = hold_q - 2'h1;
        if (hold_q == 2'h0) begin
          if (!en) begin
            state_d = ADCSS_IDLE;
          end else if (mode == ADCSS_MODE_SINGLE) begin
            chan_d = sel_chan;
            state_d = cont ? ADCSS_SAMPLE : ADCSS_HALT;
          end else if (mode == ADCSS_MODE_ONCE && cur_q >= 5'(AUTO_LAST)) begin
            state_d = ADCSS_HALT;
            ev[IRQ_SWEEP] = 1'b1;
          end else begin
            chan_d = (mode == ADCSS_MODE_ONCE) ? cur_q + 5'h01 : next_auto(cur_q);
            state_d = ADCSS_ENWAIT; // Idle out the rest of the channel slot
          end
          // Arm the timer for whichever phase comes next
          if (en && state_d == ADCSS_SAMPLE) begin
            cnt_load = 1'b1;
            cnt_val = smp_q;
            cur_d = chan_d;
          end else if (en && state_d == ADCSS_ENWAIT) begin
            cnt_load = 1'b1;
            cnt_val = pace_gap;
          end
        end
      end
      ADCSS_HALT: begin
        if (!en) begin
          state_d = ADCSS_IDLE; // Re-enable restarts with the enable delay
        end
      end
      default: begin
        state_d = ADCSS_IDLE;
      end
    endcase
    if (en && mode != ADCSS_MODE_SINGLE && avg_bad) begin
      ev[IRQ_AVG] = 1'b1; // Flags firmware misuse of averaging
    end
  end

  // Sequencer registers, all on the one core clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ADCSS_IDLE;
      chan_q <= 5'h00;
      cur_q <= 5'h00;
      hold_q <= 2'h0;
    end else begin
      state_q <= state_d;
      chan_q <= chan_d;
      cur_q <= cur_d;
      hold_q <= hold_d;
    end
  end

  // Register writes; hardware set beats software clear on status bits
  always_comb begin
    ctrl_d = ctrl_q;
    en_dly_d = en_dly_q;
    smp_d = smp_q;
    irq_mask_d = irq_mask_q;
    auto_map_d = auto_map_q;
    irq_st_d = irq_st_q;
    // Code taken as delivered; divider scaling sits ahead of the converter
    last_d = res_we ? adc_code : last_q;
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        ctrl_d = reg_wdata;
      end else if (reg_addr == REG_EN_DLY) begin
        en_dly_d = reg_wdata[15:0];
      end else if (reg_addr == REG_SMP) begin
        smp_d = reg_wdata[15:0];
      end else if (reg_addr == REG_IRQ_ST) begin
        irq_st_d = irq_st_q & ~reg_wdata[2:0];
      end else if (reg_addr == REG_IRQ_MASK) begin
        irq_mask_d = reg_wdata[2:0];
      end else if (reg_addr == REG_AUTO_MAP) begin
        auto_map_d = reg_wdata;
      end
    end
    irq_st_d = irq_st_d | ev;
    irq_d = |(irq_st_d & irq_mask_d);
  end

  // Offset into the result window; a plain address slice would alias the channels
  assign res_off = reg_addr - REG_RESULT0;

  // Read mux; reads have no side effect so the sequence is never disturbed
  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        rdata_d = ctrl_q;
      end else if (reg_addr == REG_EN_DLY) begin
        rdata_d = {16'h0000, en_dly_q};
      end else if (reg_addr == REG_SMP) begin
        rdata_d = {16'h0000, smp_q};
      end else if (reg_addr == REG_STATUS) begin
        rdata_d = {19'h00000, cur_q, 2'h0, state_q};
      end else if (reg_addr == REG_IRQ_ST) begin
        rdata_d = {29'h00000000, irq_st_q};
      end else if (reg_addr == REG_IRQ_MASK) begin
        rdata_d = {29'h00000000, irq_mask_q};
      end else if (reg_addr == REG_LAST) begin
        rdata_d = {22'h000000, last_q};
      end else if (reg_addr == REG_AUTO_MAP) begin
        rdata_d = auto_map_q;
      end else if (reg_addr >= REG_RESULT0 && res_off < 8'(4 * NCHAN) && reg_addr[1:0] == 2'h0) begin
        rdata_d = {22'h000000, result_q[res_off[6:2]]};
      end
    end
  end

  // Register file and registered outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RST;
      en_dly_q <= EN_DLY_RST;
      smp_q <= SMP_RST;
      irq_st_q <= 3'h0;
      irq_mask_q <= 3'h0;
      auto_map_q <= AUTO_MAP_RST;
      last_q <= '0;
      reg_rdata <= 32'h00000000;
      irq <= 1'b0;
      adc_done_int <= 1'b0;
      adc_chan_sel <= 5'h00;
      adc_sample <= 1'b0;
      adc_convert <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      en_dly_q <= en_dly_d;
      smp_q <= smp_d;
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      auto_map_q <= auto_map_d;
      last_q <= last_d;
      reg_rdata <= rdata_d;
      irq <= irq_d;
      adc_done_int <= (state_d == ADCSS_INTHOLD); // Two-cycle pulse
      adc_chan_sel <= cur_d;
      adc_sample <= (state_d == ADCSS_SAMPLE);
      adc_convert <= (state_d == ADCSS_CONVERT);
    end
  end

  // Per-channel result store, written only on completion
  genvar gi;
  generate
    for (gi = 0; gi < NCHAN; gi++) begin : g_res
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          result_q[gi] <= '0;
        end else if (res_we && cur_q == 5'(gi)) begin
          result_q[gi] <= adc_code;
        end
      end
    end
  endgenerate
endmodule : adcss_seq
`default_nettype wire

// ===== adcss_seq_asserts.sv
// Checker for the sense sequencer converter handshake and read port.
`timescale 1ns/100ps
`default_nettype none
module adcss_seq_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic adc_done_int,
  input wire logic [4:0] adc_chan_sel,
  input wire logic adc_sample,
  input wire logic adc_convert
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Conversion run and completion pulse shapes
  sequence conv12_s;
    adc_convert [*8] ##1 adc_convert [*4] ##1 !adc_convert;
  endsequence
  sequence hold2_s;
    adc_done_int [*2] ##1 !adc_done_int;
  endsequence
  conv_len_a: assert property ($rose(adc_convert) |-> conv12_s) else $error("convert length wrong");
  smp_first_a: assert property ($rose(adc_convert) |-> $past(adc_sample)) else $error("convert without sample");
  done_follows_a: assert property ($fell(adc_convert) |-> ##[0:1] $rose(adc_done_int)) else $error("no done");
  done_hold_a: assert property ($rose(adc_done_int) |-> hold2_s) else $error("done pulse length wrong");
  phase_excl_a: assert property (!(adc_sample && adc_convert)) else $error("sample and convert overlap");
  // Channel must not move under a running conversion
  chan_hold_a: assert property (adc_convert && $past(adc_convert) |-> $stable(adc_chan_sel)) else $error("chan moved");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000) else $error("read data outside slot");
  smp_after_a: assert property ($rose(adc_sample) |-> !adc_done_int) else $error("sample during done");
endmodule : adcss_seq_chk
`default_nettype wire

// ===== tb_adc_sense_sequencer.sv
// Testbench for the sense sequencer: register tasks, mode scenarios, verdict.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module tb_adc_sense_sequencer
  import adcss_pkg::*;
  ;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  logic irq, adc_done_int, adc_sample, adc_convert;
  logic [4:0] adc_chan_sel;
  logic [9:0] adc_code;
  logic [2:0] sv, s_q = 3'h0;
  logic [4:0] chq[$];
  int err_total = 0, comparisons = 0, ndone = 0, cyc = 0, run[3], len[3], t0[$];
  logic [7:0] ra[6] = '{REG_CTRL, REG_EN_DLY, REG_SMP, REG_IRQ_ST, REG_AUTO_MAP, 8'h3C};
  logic [31:0] rv[6] = '{32'h00010000, 32'h00000010, 32'h00000008, 32'h00000000, AUTO_MAP_RST, 32'h00000000};
  adcss_seq u_adcss_seq (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .adc_done_int(adc_done_int),
    .adc_chan_sel(adc_chan_sel), .adc_sample(adc_sample), .adc_convert(adc_convert), .adc_code(adc_code));
  adcss_conv_model u_adcss_conv_model (.clk(clk), .sys_rst(sys_rst), .adc_chan_sel(adc_chan_sel),
    .adc_convert(adc_convert), .adc_code(adc_code));
  initial begin
    forever #10 clk = ~clk;
  end
  assign sv = {adc_done_int, adc_convert, adc_sample};
  // Pulse lengths, channel and cycle at each sample start, completed conversions
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (sv[i]) run[i]++;
      else begin
        if (run[i] > 0) len[i] = run[i];
        run[i] = 0;
      end
    end
    if (sv[0] && !s_q[0]) begin
      chq.push_back(adc_chan_sel);
      t0.push_back(cyc);
    end
    cyc++;
    if (sv[2] && !s_q[2]) ndone++;
    s_q = sv;
  end
  task wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  // Data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
    `CHK(d, exp)
  endtask : rd
  task wd(input int n);
    for (int i = 0; i < 4000 * n && ndone < n; i++) @(posedge clk);
    `CHK(ndone >= n, 1'b1)
  endtask : wd
  task restart;
    wr(REG_CTRL, 32'h00010000);
    repeat (100) @(posedge clk);
    wr(REG_IRQ_ST, 32'h00000007);
    ndone = 0;
    chq.delete();
    t0.delete();
  endtask : restart
  task print_verdict;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // Watchdog: the paced sweeps need about 71k cycles in all
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
    $display("test reset done");
    wr(REG_EN_DLY, 32'h00000002);
    wr(REG_SMP, 32'h00000003);
    wr(REG_IRQ_MASK, 32'h00000007);
    wr(REG_CTRL, 32'h00010C01);
    wd(1);
    repeat (4) @(posedge clk);
    `CHK(len[0], 4)
    `CHK(len[1], 12)
    `CHK(len[2], 2)
    `CHK(irq, 1'b1)
    rd(REG_RESULT0 + 8'h30, {22'h000000, 5'h0C, 5'h0B});
    rd(REG_IRQ_ST, 32'h00000001);
    wr(REG_IRQ_ST, 32'h00000001);
    repeat (40) @(posedge clk);
    `CHK(irq, 1'b0)
    `CHK(chq.size(), 1)
    restart();
    wr(REG_CTRL, 32'h00010303);
    wd(3);
    `CHK(chq[2], 5'h03)
    `CHK(t0[1] - t0[0], 4 + CONV_CYCLES + INT_HOLD_CYCLES)
    $display("test single done");
    restart();
    wr(REG_CTRL, 32'h00010005);
    wd(2);
    rd(REG_RESULT0, 32'h0000000B);
    wd(13);
    for (int i = 0; i < 13; i++) `CHK(chq[i], 5'(i % 12))
    `CHK(t0[2] - t0[1], CHAN_CYCLES)
    `CHK(t0[12] - t0[0], 12 * CHAN_CYCLES)
    for (int i = 0; i < 12; i++) rd(REG_RESULT0 + 8'(4 * i), {22'h000000, 5'(i), 5'h0B});
    restart();
    wr(REG_CTRL, 32'h00020005);
    repeat (5) @(posedge clk);
    rd(REG_IRQ_ST, 32'h00000004);
    $display("test robin done");
    restart();
    wr(REG_IRQ_MASK, 32'h00000002);
    wr(REG_CTRL, 32'h00010009);
    for (int i = 0; i < 60000 && irq !== 1'b1; i++) @(posedge clk);
    `CHK(ndone, 11)
    repeat (100) @(posedge clk);
    `CHK(chq.size(), 11)
    `CHK(chq[10], 5'h0A)
    $display("test once done");
    print_verdict();
  end
endmodule : tb_adc_sense_sequencer
bind adcss_seq adcss_seq_chk u_adcss_seq_chk (.clk(clk), .sys_rst(sys_rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .adc_done_int(adc_done_int), .adc_chan_sel(adc_chan_sel),
  .adc_sample(adc_sample), .adc_convert(adc_convert));
`default_nettype wire
